// File: dsr_status_regs.sv
/*
 status register bank of a multi-channel converter behind ahb-lite:
 general status, compare status, latch clear and a config word.
 assumes status inputs are on hclk; the two comparator inputs are
 asynchronous and are synchronised here.
*/
// Chosen here: register access over AHB-Lite.
// Function
// - bit15 flags otp crc load failure
// - bit12 shows channel 1 busy
// - bit11 shows channel 0 busy
// - bit9 shows channel 2 busy
// - bit8 shows nonvolatile store busy
// - compare status at 0x23, reset 0x000c, read-only
// - protect flag sets, clears when read
// - bit3 synchronised compare output, resets one
// - general status at 0x22
// - trigger bit3 clears latched compare, self-clears
`timescale 1ns/1ps
module dsr_status_regs #(
   parameter int         ADDR_W  = 10,
   parameter logic [5:0] PART_ID = 6'h15, // arbitrary value
   parameter logic [1:0] REV_ID  = 2'h2   // arbitrary value
) (
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [ADDR_W-1:0]       haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire dsr_pkg::dsr_status_in_t status_in,
   input  wire logic                    window_compare_ch1_raw,
   input  wire logic                    compare_ch1_raw
);
   initial begin
      if (ADDR_W < 10) $error("ADDR_W must be at least 10");
   end

   function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
      word_idx = a[9:2];
   endfunction : word_idx

   logic       acc_w;
   logic [7:0] idx_w;
   logic       wr_pend_q;
   logic [7:0] wr_idx_q;
   logic       otp_load_crc_error_q;
   logic       user_store_crc_error_q;
   logic       protect_q;
   logic       window_compare_ch1_q;
   logic       compare_sync_ch1_q;
   logic       win_latch_en_q;
   logic       compare_latch_clear_q;
   logic       soft_reset_q;
   logic [2:0] win_sync_q;
   logic [2:0] cmp_sync_q;
   logic       win_clean_q;
   logic [15:0] gen_word_w;
   logic [15:0] cmp_word_w;
   logic       rd_cmp_w;

   assign acc_w    = hsel & htrans[1] & hready;
   assign idx_w    = word_idx(haddr);
   assign rd_cmp_w = acc_w & ~hwrite & (idx_w == dsr_pkg::IDX_COMPARE_STAT);

   // general status image; ids are constants, never written
   always_comb begin
      gen_word_w = 16'h0000;
      gen_word_w[dsr_pkg::GS_OTP_CRC]    = otp_load_crc_error_q;
      gen_word_w[dsr_pkg::GS_USER_CRC]   = user_store_crc_error_q;
      gen_word_w[dsr_pkg::GS_RSVD_ONE]   = 1'b1;
      gen_word_w[dsr_pkg::GS_BUSY1]      = status_in.chan_busy[1];
      gen_word_w[dsr_pkg::GS_BUSY0]      = status_in.chan_busy[0];
      gen_word_w[dsr_pkg::GS_BUSY2]      = status_in.chan_busy[2];
      gen_word_w[dsr_pkg::GS_STORE_BUSY] = status_in.store_busy;
      gen_word_w[dsr_pkg::GS_PART_LSB +: 6] = PART_ID;
      gen_word_w[dsr_pkg::GS_REV_LSB +: 2]  = REV_ID;
   end

   always_comb begin
      cmp_word_w = 16'h0000;
      cmp_word_w[2:0]                  = dsr_pkg::CS_RSVD_LOW;
      cmp_word_w[dsr_pkg::CS_PROTECT]  = protect_q;
      cmp_word_w[dsr_pkg::CS_WINDOW]   = window_compare_ch1_q;
      cmp_word_w[dsr_pkg::CS_SYNC]     = compare_sync_ch1_q;
   end

   // bus slave: zero wait states, read data captured in address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 8'h00;
      end else begin
         wr_pend_q <= acc_w & hwrite;
         wr_idx_q  <= idx_w;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (acc_w & ~hwrite) begin
         if (idx_w == dsr_pkg::IDX_GENERAL_STAT) begin
            hrdata <= {16'h0000, gen_word_w};
         end else if (idx_w == dsr_pkg::IDX_COMPARE_STAT) begin
            hrdata <= {16'h0000, cmp_word_w};
         end else if (idx_w == dsr_pkg::IDX_STATUS_CFG) begin
            hrdata <= {31'h0000_0000, win_latch_en_q};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // software side effects of writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_latch_en_q <= 1'b0;
      end else if (wr_pend_q && wr_idx_q == dsr_pkg::IDX_STATUS_CFG) begin
         win_latch_en_q <= hwdata[dsr_pkg::CFG_WIN_LATCH];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_latch_clear_q <= 1'b0;
         soft_reset_q          <= 1'b0;
      end else begin
         // both are one-cycle pulses that drop by themselves
         compare_latch_clear_q <= wr_pend_q
            && wr_idx_q == dsr_pkg::IDX_CHAN_TRIG
            && hwdata[dsr_pkg::CT_LATCH_CLR];
         soft_reset_q <= wr_pend_q
            && wr_idx_q == dsr_pkg::IDX_COMMON_TRIG
            && hwdata[dsr_pkg::TR_RESET_LSB +: 4] == dsr_pkg::TR_RESET_KEY;
      end
   end

   // crc error flags: load failure sets, software reset clears, set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         otp_load_crc_error_q   <= 1'b0;
         user_store_crc_error_q <= 1'b0;
      end else begin
         otp_load_crc_error_q   <= status_in.otp_crc_fail
            | (otp_load_crc_error_q & ~soft_reset_q);
         user_store_crc_error_q <= status_in.user_crc_fail
            | (user_store_crc_error_q & ~soft_reset_q);
      end
   end

   // protect flag: cleared by a read of the compare status, set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         protect_q <= 1'b0;
      end else begin
         protect_q <= status_in.protect_event | (protect_q & ~rd_cmp_w);
      end
   end

   // three-stage synchronisers; value moves once stages 2 and 3 agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_sync_q  <= 3'h0;
         win_clean_q <= 1'b0;
      end else begin
         win_sync_q <= {win_sync_q[1:0], window_compare_ch1_raw};
         if (win_sync_q[1] == win_sync_q[2]) begin
            win_clean_q <= win_sync_q[2];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_sync_q         <= {3{dsr_pkg::CS_SYNC_RST}};
         compare_sync_ch1_q <= dsr_pkg::CS_SYNC_RST;
      end else begin
         cmp_sync_q <= {cmp_sync_q[1:0], compare_ch1_raw};
         if (cmp_sync_q[1] == cmp_sync_q[2]) begin
            compare_sync_ch1_q <= cmp_sync_q[2];
         end
      end
   end

   // window output: held high until cleared when latching, else passed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         window_compare_ch1_q <= 1'b0;
      end else if (win_latch_en_q) begin
         window_compare_ch1_q <= win_clean_q
            | (window_compare_ch1_q & ~compare_latch_clear_q);
      end else begin
         window_compare_ch1_q <= win_clean_q;
      end
   end

   default clocking dcb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_OTP_SET: assert property (
      status_in.otp_crc_fail |=> otp_load_crc_error_q [*2])
      else $error("otp crc flag not set");
   AST_USER_HOLD: assert property (
      user_store_crc_error_q && !soft_reset_q |=> user_store_crc_error_q)
      else $error("user crc flag lost without reset");
   AST_BUSY_READ: assert property (
      acc_w && !hwrite && idx_w == dsr_pkg::IDX_GENERAL_STAT
      |=> hrdata[dsr_pkg::GS_BUSY1] == $past(status_in.chan_busy[1])
       && hrdata[dsr_pkg::GS_BUSY0] == $past(status_in.chan_busy[0])
       && hrdata[dsr_pkg::GS_BUSY2] == $past(status_in.chan_busy[2])
       && hrdata[dsr_pkg::GS_STORE_BUSY] == $past(status_in.store_busy))
      else $error("busy bits misreported");
   AST_CMP_LOW: assert property (
      acc_w && !hwrite && idx_w == dsr_pkg::IDX_COMPARE_STAT
      |=> hrdata[2:0] == dsr_pkg::CS_RSVD_LOW && hrdata[31:9] == 23'h0)
      else $error("compare status reserved bits wrong");
   AST_PROT_CLR: assert property (
      rd_cmp_w && !status_in.protect_event |=> !protect_q)
      else $error("protect flag not cleared on read");
   AST_PROT_SET: assert property (
      status_in.protect_event |=> protect_q)
      else $error("protect event lost");
   AST_WIN_PASS: assert property (
      !win_latch_en_q && $stable(win_latch_en_q)
      |=> window_compare_ch1_q == $past(win_clean_q))
      else $error("unlatched window output wrong");
   AST_SYNC_DELAY: assert property (
      $stable(compare_ch1_raw) [*5] |-> compare_sync_ch1_q == compare_ch1_raw)
      else $error("compare output not synchronised");
   AST_GEN_IDS: assert property (
      acc_w && !hwrite && idx_w == dsr_pkg::IDX_GENERAL_STAT
      |=> hrdata[7:0] == {PART_ID, REV_ID} && hrdata[dsr_pkg::GS_RSVD_ONE])
      else $error("general status ids wrong");
   AST_CLR_PULSE: assert property (
      compare_latch_clear_q |=> !compare_latch_clear_q || $past(wr_pend_q))
      else $error("latch clear does not self-clear");

   COV_PROT_READ: cover property (protect_q ##1 rd_cmp_w ##1 !protect_q);
   COV_LATCH: cover property (win_latch_en_q && window_compare_ch1_q
      ##1 compare_latch_clear_q);
   COV_SOFT_RST: cover property (otp_load_crc_error_q ##1 soft_reset_q);
   COV_CMP_LOW: cover property (!compare_sync_ch1_q);
endmodule : dsr_status_regs

// File: dsr_pkg.sv
/*
 package for the converter status register bank: word indices,
 field positions, reset values and the status input carrier.
 assumes byte address = 4 * word index on a 32-bit ahb-lite bus.
*/
package dsr_pkg;
   // word indices; byte address is four times the index
   localparam logic [7:0] IDX_COMMON_TRIG   = 8'h20;
   localparam logic [7:0] IDX_CHAN_TRIG     = 8'h21;
   localparam logic [7:0] IDX_GENERAL_STAT  = 8'h22;
   localparam logic [7:0] IDX_COMPARE_STAT  = 8'h23;
   localparam logic [7:0] IDX_STATUS_CFG    = 8'h30;
   // general status fields
   localparam int GS_OTP_CRC    = 15;
   localparam int GS_USER_CRC   = 14;
   localparam int GS_RSVD_ONE   = 13;
   localparam int GS_BUSY1      = 12;
   localparam int GS_BUSY0      = 11;
   localparam int GS_BUSY2      = 9;
   localparam int GS_STORE_BUSY = 8;
   localparam int GS_PART_LSB   = 2;
   localparam int GS_REV_LSB    = 0;
   // compare status fields and reset values
   localparam int CS_PROTECT    = 8;
   localparam int CS_WINDOW     = 7;
   localparam int CS_SYNC       = 3;
   localparam logic [15:0] CS_RESET    = 16'h000c;
   localparam logic [2:0]  CS_RSVD_LOW = 3'h4;
   localparam logic        CS_SYNC_RST = 1'h1;
   // write fields
   localparam int CT_LATCH_CLR  = 3;
   localparam int TR_RESET_LSB  = 8;
   localparam logic [3:0] TR_RESET_KEY = 4'ha;
   localparam int CFG_WIN_LATCH = 0;

   typedef struct packed {
      logic       otp_crc_fail;
      logic       user_crc_fail;
      logic [2:0] chan_busy;
      logic       store_busy;
      logic       protect_event;
   } dsr_status_in_t;
endpackage : dsr_pkg

// File: dsr_status_regs_tb_top.sv
/*
 testbench for the converter status register bank: an ahb-lite master,
 status pulses and comparator levels, every scenario self-checked.
 assumes hready looped back from hreadyout and one 250 mhz clock.
*/
`timescale 1ns/1ps
module dsr_status_regs_tb_top;
   localparam logic [5:0] PART = 6'h15; // arbitrary value
   localparam logic [1:0] REV  = 2'h2;  // arbitrary value
   logic                    hclk;
   logic                    hresetn;
   logic                    hsel;
   logic [9:0]              haddr;
   logic [1:0]              htrans;
   logic                    hwrite;
   logic [2:0]              hsize;
   logic [31:0]             hwdata;
   logic [31:0]             hrdata;
   logic                    hreadyout;
   logic                    hresp;
   dsr_pkg::dsr_status_in_t status_in;
   logic                    win_raw;
   logic                    cmp_raw;
   int                      err_total;
   int                      n_checks;

   dsr_status_regs #(.ADDR_W(10), .PART_ID(PART), .REV_ID(REV)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .status_in(status_in),
      .window_compare_ch1_raw(win_raw), .compare_ch1_raw(cmp_raw));

   always #2 hclk = ~hclk;

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         err_total++;
         wrap_up();
      end
   endtask : wait_rdy

   // entered just after a rising edge; address phase, then data phase
   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : bus

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, idx, 32'h0, rd);
      chk(rd, exp);
   endtask : rd_chk

   // two spare edges let trigger pulses reach the flags
   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      bus(1'b1, idx, wd, rd);
      repeat (2) @(posedge hclk);
   endtask : wr

   function automatic logic [31:0] gs(input logic o, input logic u,
                                      input logic [2:0] b, input logic s);
      return {16'h0, o, u, 1'b1, b[1], b[0], 1'b0, b[2], s, PART, REV};
   endfunction : gs

   task automatic t_reset;
      rd_chk(8'h23, 32'h0000000c);
      rd_chk(8'h22, gs(1'b0, 1'b0, 3'h0, 1'b0));
      rd_chk(8'h3f, 32'h0);
      wr(8'h22, 32'hffffffff);
      wr(8'h23, 32'hffffffff);
      rd_chk(8'h22, gs(1'b0, 1'b0, 3'h0, 1'b0));
      rd_chk(8'h23, 32'h0000000c);
   endtask : t_reset

   task automatic t_busy;
      for (int i = 0; i < 16; i++) begin
         status_in.chan_busy  <= i[2:0];
         status_in.store_busy <= i[3];
         @(posedge hclk);
         rd_chk(8'h22, gs(1'b0, 1'b0, i[2:0], i[3]));
      end
      status_in.chan_busy  <= 3'h0;
      status_in.store_busy <= 1'b0;
      @(posedge hclk);
   endtask : t_busy

   task automatic t_crc;
      status_in.otp_crc_fail <= 1'b1;
      @(posedge hclk);
      status_in.otp_crc_fail <= 1'b0;
      @(posedge hclk);
      rd_chk(8'h22, gs(1'b1, 1'b0, 3'h0, 1'b0));
      status_in.user_crc_fail <= 1'b1;
      @(posedge hclk);
      status_in.user_crc_fail <= 1'b0;
      @(posedge hclk);
      rd_chk(8'h22, gs(1'b1, 1'b1, 3'h0, 1'b0));
      wr(8'h20, 32'h00000500);
      rd_chk(8'h22, gs(1'b1, 1'b1, 3'h0, 1'b0));
      wr(8'h20, 32'h00000a00);
      rd_chk(8'h22, gs(1'b0, 1'b0, 3'h0, 1'b0));
   endtask : t_crc

   task automatic t_protect;
      status_in.protect_event <= 1'b1;
      @(posedge hclk);
      status_in.protect_event <= 1'b0;
      @(posedge hclk);
      rd_chk(8'h23, 32'h0000010c);
      rd_chk(8'h23, 32'h0000000c);
   endtask : t_protect

   task automatic t_compare;
      win_raw <= 1'b1;
      repeat (10) @(posedge hclk);
      rd_chk(8'h23, 32'h0000008c);
      win_raw <= 1'b0;
      repeat (10) @(posedge hclk);
      rd_chk(8'h23, 32'h0000000c);
      wr(8'h30, 32'h1);
      rd_chk(8'h30, 32'h1);
      win_raw <= 1'b1;
      repeat (10) @(posedge hclk);
      win_raw <= 1'b0;
      cmp_raw <= 1'b0;
      repeat (10) @(posedge hclk);
      rd_chk(8'h23, 32'h00000084);
      wr(8'h21, 32'h00000008);
      rd_chk(8'h23, 32'h00000004);
      rd_chk(8'h21, 32'h0);
      cmp_raw <= 1'b1;
      repeat (10) @(posedge hclk);
      rd_chk(8'h23, 32'h0000000c);
   endtask : t_compare

   initial begin
      hclk      = 1'b0;
      hresetn   = 1'b0;
      hsel      = 1'b0;
      haddr     = 10'h0;
      htrans    = 2'b00;
      hwrite    = 1'b0;
      hsize     = 3'h2;
      hwdata    = 32'h0;
      status_in = '0;
      win_raw   = 1'b0;
      cmp_raw   = 1'b1;
      err_total = 0;
      n_checks  = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_reset();
      t_busy();
      t_crc();
      t_protect();
      t_compare();
      wrap_up();
   end
endmodule : dsr_status_regs_tb_top
